// ===== include/rpt_cfg.svh
// Register offsets, field positions and reset values of the reload PWM timer.
`ifndef RPT_CFG_SVH
`define RPT_CFG_SVH
`define RPT_IDX_DUTY1 8'h14
`define RPT_IDX_DUTY0 8'h15
`define RPT_IDX_PWMCTL 8'h16
`define RPT_IDX_TCS 8'h17
`define RPT_IDX_CNT 8'h18
`define RPT_IDX_RLD 8'h19
`define RPT_IDX_CCS 8'h1A
`define RPT_IDX_CAP1 8'h1B
`define RPT_IDX_CAP2 8'h1C
`define RPT_IDX_TBCNT 8'h36
`define RPT_IDX_TBCS 8'h37
`define RPT_IDX_SYS 8'h40
`define RPT_ADDR_BITS 10
`define RPT_RESET_BYTE 8'h00
`define RPT_TCS_EXT_CLK_SELECT 7
`define RPT_TCS_RUN 3
`define RPT_TCS_FRL 2
`define RPT_TCS_IE 1
`define RPT_TCS_FLAG 0
`define RPT_TBCS_CHAIN 6
`define RPT_TBCS_FLAG 5
`define RPT_TBCS_IE 4
`define RPT_TBCS_RUN 3
`define RPT_SYS_HALT 0
`define RPT_SYS_WAIT 1
`endif

// ===== include/rpt_pkg.sv
// Types shared by the reload PWM timer.
package rpt_pkg;
   typedef struct packed {
      logic ext_clk_select;
      logic [2:0] count_clk_div;
      logic counter_run;
      logic wrap_irq_en;
   } rpt_tcs_t;
   typedef struct packed {
      logic tb_chain_en;
      logic tb_irq_en;
      logic tb_run;
      logic [2:0] tb_div_sel;
   } rpt_tbcs_t;
   typedef enum logic [1:0] {
      RPT_ADDR = 2'b01,
      RPT_DATA = 2'b10
   } rpt_bus_state_t;
endpackage : rpt_pkg

// ===== core/rpt_timer.sv
// Reload PWM timer with input capture and chained timebase, AHB-Lite slave.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "rpt_cfg.svh"
module rpt_timer (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_ext_clk,
   input wire logic [1:0] i_capture_in,
   output logic [1:0] o_pwm_out,
   output logic [1:0] o_pwm_out_oe,
   output logic o_wrap_irq,
   output logic o_capture_irq,
   output logic o_tb_irq,
   output logic o_tb_wake
);
   rpt_pkg::rpt_tcs_t tcs;
   rpt_pkg::rpt_tbcs_t tbcs;
   logic [7:0] duty [2], shadow [2], cap_val [2];
   logic [1:0] pwm_out_en, pwm_out_invert, capture_edge_sel, capture_irq_en, capture_flag;
   logic wrap_flag, tb_flag;
   logic [7:0] counter, reload_value, tb_count, tb_presc;
   logic [6:0] presc;
   logic [1:0] low_power, pwm_raw;
   logic [2:0] ext_sync, cap_sync [2];
   logic ext_level, ext_level_q;
   logic [1:0] cap_level, cap_level_q;

   // Address-phase capture and the one-cycle enables of the counters.
   logic wr_pend, acc_ok, wr_now, rd_now;
   logic [7:0] pend_idx, wbyte, next_rdata;
   logic in_tick, cnt_tick, wrap, tb_tick, tb_wrap;
   logic [1:0] cap_evt;

   function automatic logic [7:0] idx_of(input logic [31:0] addr);
      idx_of = addr[`RPT_ADDR_BITS-1:2];
   endfunction : idx_of

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
      is_reg = (a == r);
   endfunction : is_reg

   assign acc_ok = i_hsel && i_hready && i_htrans[1];
   assign wr_now = wr_pend;
   assign rd_now = acc_ok && !i_hwrite;
   assign wbyte = i_hwdata[7:0];

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_pend <= 1'b0;
         pend_idx <= `RPT_RESET_BYTE;
      end
      else
      begin
         wr_pend <= acc_ok && i_hwrite;
         pend_idx <= acc_ok ? idx_of(i_haddr) : pend_idx;
      end
   end

   // Pin inputs pass three flops; a level changes only when stages two and three agree.
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ext_sync <= 3'h0;
         cap_sync[0] <= 3'h0;
         cap_sync[1] <= 3'h0;
         ext_level <= 1'b0;
         ext_level_q <= 1'b0;
         cap_level <= 2'h0;
         cap_level_q <= 2'h0;
      end
      else
      begin
         ext_sync <= {ext_sync[1:0], i_ext_clk};
         cap_sync[0] <= {cap_sync[0][1:0], i_capture_in[0]};
         cap_sync[1] <= {cap_sync[1][1:0], i_capture_in[1]};
         if (ext_sync[1] == ext_sync[2])
            ext_level <= ext_sync[2];
         for (int i = 0; i < 2; i++)
            if (cap_sync[i][1] == cap_sync[i][2])
               cap_level[i] <= cap_sync[i][2];
         ext_level_q <= ext_level;
         cap_level_q <= cap_level;
      end
   end

   // Prescaler source: every system cycle, or each rising external edge.
   assign in_tick = tcs.ext_clk_select ? (ext_level && !ext_level_q) : 1'b1;
   // Tap select: all low bits set means the 2^n divider rolls this tick.
   assign cnt_tick = tcs.counter_run && in_tick
      && ((presc | ~((7'h01 << tcs.count_clk_div) - 7'h01)) == 7'h7F);
   assign wrap = cnt_tick && (counter == 8'hFF);
   assign tb_tick = tbcs.tb_chain_en ? (wrap && !low_power[`RPT_SYS_HALT])
      : (tbcs.tb_run && !low_power[`RPT_SYS_HALT]
         && ((tb_presc | ~((8'h02 << tbcs.tb_div_sel) - 8'h01)) == 8'hFF));
   assign tb_wrap = tb_tick && (tb_count == 8'hFF);

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         presc <= 7'h00;
      else if (wr_now && (is_reg(pend_idx, `RPT_IDX_CNT)
         || (is_reg(pend_idx, `RPT_IDX_TCS) && wbyte[`RPT_TCS_FRL])))
         presc <= 7'h00;
      else if (tcs.counter_run && in_tick)
         presc <= presc + 7'h01;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         counter <= `RPT_RESET_BYTE;
      else if (wr_now && is_reg(pend_idx, `RPT_IDX_CNT))
         counter <= wbyte;
      else if (wr_now && is_reg(pend_idx, `RPT_IDX_TCS) && wbyte[`RPT_TCS_FRL])
         counter <= reload_value;
      else if (wrap)
         counter <= reload_value;
      else if (cnt_tick)
         counter <= counter + 8'h01;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         tb_presc <= 8'h00;
      else if (!tbcs.tb_run || low_power[`RPT_SYS_HALT])
         tb_presc <= 8'h00;
      else
         tb_presc <= tb_presc + 8'h01;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         tb_count <= `RPT_RESET_BYTE;
      else if (wr_now && is_reg(pend_idx, `RPT_IDX_TBCNT))
         tb_count <= wbyte;
      else if (tb_tick)
         tb_count <= tb_count + 8'h01;
   end

   // Control registers.
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tcs <= '0;
         tbcs <= '0;
         reload_value <= `RPT_RESET_BYTE;
         duty[0] <= `RPT_RESET_BYTE;
         duty[1] <= `RPT_RESET_BYTE;
         pwm_out_en <= 2'h0;
         pwm_out_invert <= 2'h0;
         capture_edge_sel <= 2'h0;
         capture_irq_en <= 2'h0;
         low_power <= 2'h0;
      end
      else if (wr_now)
      begin
         if (is_reg(pend_idx, `RPT_IDX_TCS))
            tcs <= '{wbyte[7], wbyte[6:4], wbyte[3], wbyte[1]};
         else if (is_reg(pend_idx, `RPT_IDX_TBCS))
            tbcs <= '{wbyte[6], wbyte[4], wbyte[3], wbyte[2:0]};
         else if (is_reg(pend_idx, `RPT_IDX_RLD))
            reload_value <= wbyte;
         else if (is_reg(pend_idx, `RPT_IDX_DUTY0))
            duty[0] <= wbyte;
         else if (is_reg(pend_idx, `RPT_IDX_DUTY1))
            duty[1] <= wbyte;
         else if (is_reg(pend_idx, `RPT_IDX_PWMCTL))
         begin
            pwm_out_en <= wbyte[5:4];
            pwm_out_invert <= wbyte[1:0];
         end
         else if (is_reg(pend_idx, `RPT_IDX_CCS))
         begin
            capture_edge_sel <= wbyte[5:4];
            capture_irq_en <= wbyte[3:2];
         end
         else if (is_reg(pend_idx, `RPT_IDX_SYS))
            low_power <= wbyte[1:0];
      end
   end

   // Flags: a hardware set in the same cycle as a read-clear wins.
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wrap_flag <= 1'b0;
         tb_flag <= 1'b0;
      end
      else
      begin
         if (wrap)
            wrap_flag <= 1'b1;
         else if (rd_now && is_reg(idx_of(i_haddr), `RPT_IDX_TCS))
            wrap_flag <= 1'b0;
         if (tb_wrap)
            tb_flag <= 1'b1;
         else if (rd_now && is_reg(idx_of(i_haddr), `RPT_IDX_TBCS))
            tb_flag <= 1'b0;
      end
   end

   // Capture: edge seen on the synchronised pin, taken on the prescaler source tick, halted in halt.
   generate
      for (genvar c = 0; c < 2; c++)
      begin : g_ch
         logic edge_seen;
         assign cap_evt[c] = edge_seen && in_tick && !low_power[`RPT_SYS_HALT];
         always_ff @(posedge i_ref_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
               edge_seen <= 1'b0;
            else if (cap_evt[c])
               edge_seen <= 1'b0;
            else if (cap_level[c] != cap_level_q[c]
               && cap_level[c] == capture_edge_sel[c])
               edge_seen <= 1'b1;
         end
         always_ff @(posedge i_ref_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
            begin
               cap_val[c] <= `RPT_RESET_BYTE;
               capture_flag[c] <= 1'b0;
            end
            else
            begin
               if (cap_evt[c] && !capture_flag[c])
                  cap_val[c] <= counter;
               if (cap_evt[c])
                  capture_flag[c] <= 1'b1;
               else if (rd_now && is_reg(idx_of(i_haddr), `RPT_IDX_CCS))
                  capture_flag[c] <= 1'b0;
            end
         end
         always_ff @(posedge i_ref_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
               shadow[c] <= `RPT_RESET_BYTE;
            else if (wrap)
               shadow[c] <= duty[c];
         end
         // Level after polarity, before the enable; reload sets the first edge, compare the second.
         always_comb
         begin
            if (shadow[c] == 8'hFF)
               pwm_raw[c] = pwm_out_invert[c];
            else if (shadow[c] == 8'h00)
               pwm_raw[c] = !pwm_out_invert[c];
            else
               pwm_raw[c] = (counter <= shadow[c]) ^ pwm_out_invert[c];
         end
         a_pwm_polarity: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
            $changed(pwm_out_invert[c]) && $stable(counter) && $stable(shadow[c])
            |=> o_pwm_out[c] != $past(o_pwm_out[c]) || !pwm_out_en[c])
            else $error("Polarity change did not flip output.");
      end
   endgenerate

   // Outputs, all registered. A disabled channel releases its pin and drives low.
   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pwm_out <= 2'h0;
         o_pwm_out_oe <= 2'h0;
         o_wrap_irq <= 1'b0;
         o_capture_irq <= 1'b0;
         o_tb_irq <= 1'b0;
         o_tb_wake <= 1'b0;
      end
      else
      begin
         o_pwm_out <= pwm_raw & pwm_out_en;
         o_pwm_out_oe <= pwm_out_en;
         o_wrap_irq <= wrap_flag && tcs.wrap_irq_en;
         o_capture_irq <= |(capture_flag & capture_irq_en);
         o_tb_irq <= tb_flag && tbcs.tb_irq_en;
         o_tb_wake <= tb_flag && tbcs.tb_irq_en && !low_power[`RPT_SYS_HALT];
      end
   end

   // Read data for the address-phase index; a status read clears its flags at this same edge.
   always_comb
   begin
      next_rdata = 8'h00;
      if (is_reg(idx_of(i_haddr), `RPT_IDX_TCS))
         next_rdata = {tcs.ext_clk_select, tcs.count_clk_div, tcs.counter_run, 1'b0,
            tcs.wrap_irq_en, wrap_flag};
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_CNT))
         next_rdata = counter;
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_RLD))
         next_rdata = reload_value;
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_DUTY0))
         next_rdata = duty[0];
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_DUTY1))
         next_rdata = duty[1];
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_PWMCTL))
         next_rdata = {2'h0, pwm_out_en, 2'h0, pwm_out_invert};
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_CCS))
         next_rdata = {2'h0, capture_edge_sel, capture_irq_en, capture_flag};
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_CAP1))
         next_rdata = cap_val[0];
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_CAP2))
         next_rdata = cap_val[1];
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_TBCNT))
         next_rdata = tb_count;
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_TBCS))
         next_rdata = {1'b0, tbcs.tb_chain_en, tb_flag, tbcs.tb_irq_en, tbcs.tb_run,
            tbcs.tb_div_sel};
      else if (is_reg(idx_of(i_haddr), `RPT_IDX_SYS))
         next_rdata = {6'h00, low_power};
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         if (rd_now)
            o_hrdata <= {24'h00_0000, next_rdata};
      end
   end

   a_wrap_reload: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wrap && !wr_now |=> counter == $past(reload_value))
      else $error("Counter did not reload on overflow.");
   a_wrap_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wrap |=> wrap_flag)
      else $error("Overflow flag not set.");
   a_wrap_irq: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !tcs.wrap_irq_en ##1 !tcs.wrap_irq_en |-> !o_wrap_irq)
      else $error("Overflow request while disabled.");
   a_run_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !tcs.counter_run && !wr_now |=> $stable(counter) && $stable(presc))
      else $error("Counter moved while stopped.");
   a_shadow_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !wrap |=> $stable(shadow[0]) && $stable(shadow[1]))
      else $error("Compare shadow changed outside overflow.");
   a_cap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      capture_flag[0] |=> $stable(cap_val[0]))
      else $error("Capture value overwritten while flagged.");
   a_tb_roll: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      tb_wrap && !wr_now |=> tb_count == 8'h00 && tb_flag)
      else $error("Timebase rollover not flagged.");
   a_cnt_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_now && is_reg(pend_idx, `RPT_IDX_CNT) |=> counter == $past(wbyte) && presc == 7'h00)
      else $error("Counter write not applied.");
endmodule : rpt_timer

// ===== tb/rpt_partner.sv
// Far-side model: capture signal sources, external count clock and PWM loads.
`timescale 1ns/1ps
module rpt_partner (
   input wire logic i_ref_clk,
   input wire logic [1:0] i_pwm_out,
   input wire logic [1:0] i_pwm_out_oe,
   output logic [1:0] o_capture_in,
   output logic o_ext_clk
);
   logic [1:0] pin_level;
   // A released pin is pulled low by the load.
   assign pin_level = i_pwm_out & i_pwm_out_oe;
   initial
   begin
      o_capture_in = 2'b10;
      o_ext_clk = 1'b0;
   end
   // Each level is held well past the synchroniser and the capture tick.
   task automatic set_cap(input int ch, input logic lvl);
      @(posedge i_ref_clk);
      o_capture_in[ch] <= lvl;
      repeat (9) @(posedge i_ref_clk);
   endtask : set_cap
   // The event clock idles low and only pulses when asked to.
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge i_ref_clk);
         o_ext_clk <= 1'b1;
         repeat (4) @(posedge i_ref_clk);
         o_ext_clk <= 1'b0;
         repeat (4) @(posedge i_ref_clk);
      end
   endtask : ext_pulses
endmodule : rpt_partner

// ===== tb/reload_pwm_timer_capture_timebase_tb_top.sv
// Self-checking testbench of the reload PWM timer.
`timescale 1ns/1ps
`include "rpt_cfg.svh"
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module reload_pwm_timer_capture_timebase_tb_top;
   logic ref_clk;
   logic reset_n;
   logic hsel;
   logic hwrite;
   logic hready;
   logic hresp;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic ext_clk;
   logic [1:0] cap_in;
   logic [1:0] pwm;
   logic [1:0] pwm_oe;
   logic wrap_irq;
   logic cap_irq;
   logic tb_irq;
   logic tb_wake;
   logic [7:0] q;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   rpt_timer dut_u (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_ext_clk(ext_clk), .i_capture_in(cap_in), .o_pwm_out(pwm),
      .o_pwm_out_oe(pwm_oe), .o_wrap_irq(wrap_irq), .o_capture_irq(cap_irq),
      .o_tb_irq(tb_irq), .o_tb_wake(tb_wake)
   );
   rpt_partner partner_u (
      .i_ref_clk(ref_clk), .i_pwm_out(pwm), .i_pwm_out_oe(pwm_oe),
      .o_capture_in(cap_in), .o_ext_clk(ext_clk)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h got %h", n, e, g);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         mismatches++;
         summarize();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   // One single word transfer; the byte address is four times the index.
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hready !== 1'b1);
      q = hrdata[7:0];
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      `CHK(n, e, q);
   endtask : rd
   task automatic t_reset();
      logic [7:0] a [12] = '{`RPT_IDX_DUTY1, `RPT_IDX_DUTY0, `RPT_IDX_PWMCTL,
         `RPT_IDX_TCS, `RPT_IDX_CNT, `RPT_IDX_RLD, `RPT_IDX_CCS, `RPT_IDX_CAP1,
         `RPT_IDX_CAP2, `RPT_IDX_TBCNT, `RPT_IDX_TBCS, 8'h20};
      foreach (a[i]) rd("reset value", a[i], 8'h00);
      `CHK("outputs", 7'h00, {pwm, pwm_oe, wrap_irq, cap_irq, tb_irq});
      `CHK("hresp", 1'b0, hresp);
   endtask : t_reset
   task automatic t_count();
      wr(`RPT_IDX_CNT, 8'h10);
      partner_u.ext_pulses(2);
      rd("frozen", `RPT_IDX_CNT, 8'h10);
      wr(`RPT_IDX_TCS, 8'h88);
      cyc(20);
      rd("ext idle", `RPT_IDX_CNT, 8'h10);
      partner_u.ext_pulses(5);
      cyc(6);
      rd("ext count", `RPT_IDX_CNT, 8'h15);
      wr(`RPT_IDX_TCS, 8'h78);
      wr(`RPT_IDX_CNT, 8'h40);
      rd("on the fly", `RPT_IDX_CNT, 8'h40);
      for (int c = 0; c < 8; c++)
      begin
         wr(`RPT_IDX_TCS, 8'h00);
         wr(`RPT_IDX_CNT, 8'h00);
         wr(`RPT_IDX_TCS, {1'b0, 3'(c), 4'h8});
         cyc(200);
         wr(`RPT_IDX_TCS, 8'h00);
         bus(1'b0, `RPT_IDX_CNT, 8'h00);
         `CHK("rate", 1, q >= 8'(200 >> c) && q <= 8'(203 >> c) + 8'd2);
      end
   endtask : t_count
   task automatic t_wrap();
      wr(`RPT_IDX_RLD, 8'hF0);
      wr(`RPT_IDX_TCS, 8'h0E);
      rd("reload bit", `RPT_IDX_TCS, 8'h0A);
      for (int i = 0; i < 40 && wrap_irq !== 1'b1; i++) @(posedge ref_clk);
      `CHK("wrap irq", 1'b1, wrap_irq);
      wr(`RPT_IDX_TCS, 8'h02);
      bus(1'b0, `RPT_IDX_CNT, 8'h00);
      `CHK("reloaded", 1, q >= 8'hF0);
      rd("flag", `RPT_IDX_TCS, 8'h03);
      rd("flag cleared", `RPT_IDX_TCS, 8'h02);
      cyc(2);
      `CHK("irq low", 1'b0, wrap_irq);
      wr(`RPT_IDX_TCS, 8'h08);
      cyc(40);
      `CHK("masked", 1'b0, wrap_irq);
      wr(`RPT_IDX_TCS, 8'h00);
      rd("flag masked", `RPT_IDX_TCS, 8'h01);
   endtask : t_wrap
   task automatic t_pwm();
      int n;
      wr(`RPT_IDX_RLD, 8'h00);
      wr(`RPT_IDX_DUTY0, 8'h00);
      wr(`RPT_IDX_DUTY1, 8'hFF);
      wr(`RPT_IDX_PWMCTL, 8'h30);
      wr(`RPT_IDX_TCS, 8'h0C);
      cyc(300);
      `CHK("enables", 2'b11, pwm_oe);
      n = 0;
      repeat (256)
      begin
         @(posedge ref_clk);
         if (pwm === 2'b01) n++;
      end
      `CHK("constant", 256, n);
      wr(`RPT_IDX_PWMCTL, 8'h33);
      cyc(2);
      `CHK("inverted", 2'b10, pwm);
      wr(`RPT_IDX_PWMCTL, 8'h10);
      wr(`RPT_IDX_TCS, 8'h00);
      wr(`RPT_IDX_CNT, 8'hC0);
      wr(`RPT_IDX_DUTY0, 8'h80);
      cyc(4);
      `CHK("no early copy", 2'b01, pwm);
      `CHK("one enable", 2'b01, pwm_oe);
      `CHK("pin level", 2'b01, partner_u.pin_level);
      wr(`RPT_IDX_PWMCTL, 8'h11);
      cyc(2);
      `CHK("stopped invert", 2'b00, pwm);
      wr(`RPT_IDX_PWMCTL, 8'h10);
      wr(`RPT_IDX_TCS, 8'h08);
      cyc(300);
      n = 0;
      repeat (256)
      begin
         @(posedge ref_clk);
         if (pwm === 2'b01) n++;
      end
      `CHK("high time", 129, n);
      wr(`RPT_IDX_TCS, 8'h00);
   endtask : t_pwm
   task automatic t_cap();
      wr(`RPT_IDX_CCS, 8'hDC);
      rd("capture ctrl", `RPT_IDX_CCS, 8'h1C);
      wr(`RPT_IDX_CNT, 8'h5A);
      wr(`RPT_IDX_TCS, 8'h78);
      partner_u.set_cap(0, 1'b1);
      `CHK("capture irq", 1'b1, cap_irq);
      wr(`RPT_IDX_CNT, 8'h77);
      partner_u.set_cap(0, 1'b0);
      partner_u.set_cap(0, 1'b1);
      rd("held", `RPT_IDX_CAP1, 8'h5A);
      rd("flags", `RPT_IDX_CCS, 8'h1D);
      cyc(2);
      `CHK("irq low", 1'b0, cap_irq);
      partner_u.set_cap(1, 1'b0);
      rd("second", `RPT_IDX_CAP2, 8'h77);
      rd("flags 2", `RPT_IDX_CCS, 8'h1E);
      rd("cleared", `RPT_IDX_CCS, 8'h1C);
      wr(`RPT_IDX_TCS, 8'h00);
   endtask : t_cap
   task automatic t_tb();
      logic [7:0] h;
      wr(`RPT_IDX_TBCS, 8'h18);
      wr(`RPT_IDX_TBCNT, 8'hFC);
      for (int i = 0; i < 40 && tb_irq !== 1'b1; i++) @(posedge ref_clk);
      `CHK("tb irq", 1'b1, tb_irq);
      `CHK("wake", 1'b1, tb_wake);
      wr(`RPT_IDX_SYS, 8'h01);
      cyc(2);
      `CHK("halt wake", 1'b0, tb_wake);
      bus(1'b0, `RPT_IDX_TBCNT, 8'h00);
      h = q;
      cyc(20);
      rd("halted", `RPT_IDX_TBCNT, h);
      wr(`RPT_IDX_SYS, 8'h00);
      rd("tb flag", `RPT_IDX_TBCS, 8'h38);
      rd("tb clear", `RPT_IDX_TBCS, 8'h18);
      for (int c = 0; c < 8; c++)
      begin
         wr(`RPT_IDX_TBCS, 8'h00);
         wr(`RPT_IDX_TBCNT, 8'h00);
         wr(`RPT_IDX_TBCS, {5'h01, 3'(c)});
         cyc(500);
         wr(`RPT_IDX_TBCS, 8'h00);
         bus(1'b0, `RPT_IDX_TBCNT, 8'h00);
         `CHK("tb rate", 1, q >= 8'(500 >> (c + 1)) && q <= 8'(503 >> (c + 1)) + 8'd2);
      end
      wr(`RPT_IDX_TBCNT, 8'h00);
      wr(`RPT_IDX_CNT, 8'hF8);
      wr(`RPT_IDX_TBCS, 8'h48);
      wr(`RPT_IDX_TCS, 8'h08);
      cyc(30);
      wr(`RPT_IDX_TCS, 8'h00);
      rd("chained", `RPT_IDX_TBCNT, 8'h01);
   endtask : t_tb
   initial
   begin
      reset_n = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_count();
      t_wrap();
      t_pwm();
      t_cap();
      t_tb();
      summarize();
   end
endmodule : reload_pwm_timer_capture_timebase_tb_top
